// [core/epa_pkg.sv]
// constants, offsets and types of the energy pulse accumulator
package epa_pkg;
  // clock and accumulation rate
  localparam int CLK_KHZ = 100000;
  localparam int ACC_KHZ = 1000;
  localparam int TICK_DIV = CLK_KHZ / ACC_KHZ;
  // pulse timing in ms
  localparam int MIN_PERIOD_MS = 10;
  localparam int LONG_PERIOD_MS = 160;
  localparam int LONG_WIDTH_MS = 80;
  // quanta counting
  localparam int HUNDREDTHS_PER_TENTH = 10;
  localparam int HUNDREDTHS_PER_PULSE = 100;
  // channel layout: group = phase a, b, c, sum; quantity per group
  localparam int NUM_PHASE = 3;
  localparam int NUM_GRP = 4;
  localparam int NUM_QTY = 5;
  localparam int NUM_CH = NUM_GRP * NUM_QTY;
  localparam int GRP_SUM = 3;
  localparam int QTY_ACT = 0;
  localparam int QTY_REACT = 1;
  localparam int QTY_APP = 2;
  localparam int QTY_FUND = 3;
  localparam int QTY_HARM = 4;
  localparam int NUM_CF = 4;
  // register offsets (word index)
  localparam logic [7:0] SYS_STATUS_ONE_OFF = 8'h02;
  localparam logic [7:0] DIR_IRQ_ENABLE_OFF = 8'h05;
  localparam logic [7:0] SOFT_RESET_OFF = 8'h70;
  localparam logic [7:0] ENERGY_STATUS_ZERO_OFF = 8'h71;
  localparam logic [7:0] PL_CONST_HI_OFF = 8'h31;
  localparam logic [7:0] PL_CONST_LO_OFF = 8'h32;
  localparam logic [7:0] METERING_MODE_OFF = 8'h33;
  localparam logic [7:0] PSTART_OFF = 8'h35;
  localparam logic [7:0] QSTART_OFF = 8'h36;
  localparam logic [7:0] SSTART_OFF = 8'h37;
  localparam logic [7:0] PHASE_NOLOAD_OFF = 8'h38;
  localparam logic [7:0] ENERGY_BASE_OFF = 8'h80;
  localparam logic [7:0] ENERGY_COUNT = 8'h28;
  // metering mode fields
  localparam int MM_PHASE_EN_LSB = 0;
  localparam int MM_ACT_ABS_BIT = 3;
  localparam int MM_REACT_ABS_BIT = 4;
  localparam int MM_CF2_REACT_BIT = 7;
  localparam int MM_CF2_APP_BIT = 8;
  localparam int MM_RES_BIT = 9;
  // status fields
  localparam int ES_APP_NOLOAD_BIT = 13;
  localparam int ES_ACT_NOLOAD_BIT = 14;
  localparam int ES_REACT_NOLOAD_BIT = 15;
  localparam int SS_ACT_DIR_LSB = 4;
  localparam int SS_REACT_DIR_LSB = 0;
  localparam int SS_DIR_CHANGE_BIT = 15;
  // reset values
  localparam logic [15:0] METERING_MODE_RST = 16'h0087;
  localparam logic [15:0] START_TH_RST = 16'hffff;
  localparam logic [15:0] PHASE_NOLOAD_RST = 16'h0000;
  localparam logic [31:0] PL_CONST_RST = 32'h0001_0000;
  localparam logic [15:0] SOFT_RESET_KEY = 16'h5a5a;
  typedef enum logic {SH_IDLE, SH_HIGH} epa_shaper_e;
endpackage

// [core/epa_chan_if.sv]
// link between the top and one accumulation channel
`timescale 1ns/10ps
interface epa_chan_if;
  logic signed [31:0] power;
  logic [31:0] quantum;
  logic tick;
  logic enable;
  logic hundredthRes;
  logic fwdPulse;
  logic revPulse;
  logic [15:0] fwdEnergy;
  logic [15:0] revEnergy;
  modport chan (input power, quantum, tick, enable, hundredthRes,
    output fwdPulse, revPulse, fwdEnergy, revEnergy);
  modport ctrl (output power, quantum, tick, enable, hundredthRes,
    input fwdPulse, revPulse, fwdEnergy, revEnergy);
endinterface

// [core/epa_channel.sv]
// one bidirectional energy accumulator with its energy registers
`timescale 1ns/10ps
module epa_channel (
  input wire logic sys_clk,
  input wire logic rst,
  epa_chan_if.chan ch
);
  logic signed [39:0] acc;
  logic signed [39:0] next_acc;
  logic signed [39:0] sum;
  logic signed [39:0] quant;
  logic fwdQuant;
  logic revQuant;
  logic [6:0] fwdHund;
  logic [6:0] revHund;
  logic [3:0] fwdTenth;
  logic [3:0] revTenth;

  assign quant = $signed({8'h00, ch.quantum});
  assign sum = acc + 40'(ch.power);

  // one signed sum, so small opposite flows cancel [RQ3]
  always_comb
  begin
    next_acc = acc;
    fwdQuant = 1'b0;
    revQuant = 1'b0;
    if (ch.tick && ch.enable)
    begin
      next_acc = sum; // [RQ1]
      if (sum >= quant)
      begin
        next_acc = sum - quant; // remainder kept [RQ4]
        fwdQuant = 1'b1; // [RQ2]
      end
      else if (sum <= -quant)
      begin
        next_acc = sum + quant; // [RQ4]
        revQuant = 1'b1; // [RQ2]
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      acc <= '0;
    else
      acc <= next_acc;
  end

  // hundredths to tenths and whole pulses
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      fwdHund <= '0;
      revHund <= '0;
      fwdTenth <= '0;
      revTenth <= '0;
      ch.fwdEnergy <= '0;
      ch.revEnergy <= '0;
      ch.fwdPulse <= 1'b0;
      ch.revPulse <= 1'b0;
    end
    else
    begin
      ch.fwdPulse <= 1'b0;
      ch.revPulse <= 1'b0;
      if (fwdQuant)
      begin
        fwdHund <= (fwdHund == 7'(epa_pkg::HUNDREDTHS_PER_PULSE - 1)) ? '0 : fwdHund + 7'd1;
        ch.fwdPulse <= (fwdHund == 7'(epa_pkg::HUNDREDTHS_PER_PULSE - 1)); // [RQ7]
        fwdTenth <= (fwdTenth == 4'(epa_pkg::HUNDREDTHS_PER_TENTH - 1)) ? '0 : fwdTenth + 4'd1;
        if (ch.hundredthRes || fwdTenth == 4'(epa_pkg::HUNDREDTHS_PER_TENTH - 1))
          ch.fwdEnergy <= ch.fwdEnergy + 16'd1; // [RQ6]
      end
      if (revQuant)
      begin
        revHund <= (revHund == 7'(epa_pkg::HUNDREDTHS_PER_PULSE - 1)) ? '0 : revHund + 7'd1;
        ch.revPulse <= (revHund == 7'(epa_pkg::HUNDREDTHS_PER_PULSE - 1)); // [RQ7]
        revTenth <= (revTenth == 4'(epa_pkg::HUNDREDTHS_PER_TENTH - 1)) ? '0 : revTenth + 4'd1;
        if (ch.hundredthRes || revTenth == 4'(epa_pkg::HUNDREDTHS_PER_TENTH - 1))
          ch.revEnergy <= ch.revEnergy + 16'd1; // [RQ6]
      end
    end
  end
endmodule // epa_channel

// [core/epa_energy_pulse_accumulator.sv]
// energy accumulation, energy registers and regulated pulse outputs
//
// Operation
// RQ1 - add the power value once per 1 MHz accumulation tick
// RQ2 - energy quantum is one hundredth of a pulse
// RQ3 - forward and reverse energy cancel inside one signed accumulator
// RQ4 - on a quantum, subtract it and keep the remainder
// RQ5 - metering mode bit 9 picks tenth or hundredth register resolution
// RQ6 - energy registers step at the selected resolution
// RQ7 - each full pulse emits output pulse and updates direction flags bits 7..0
// RQ8 - flag and interrupt when total active pulse direction changes, if enabled
// RQ9 - sum power from phases; mode bits 0..4 pick phases and absolute summing
// RQ10 - twenty total energy registers, five kinds for three phases and sum; the code keeps a forward and a reverse register for each, 40 in all
// RQ11 - sixteen fundamental and harmonic active registers, reactive not split
// RQ12 - first output carries sum active energy, both directions
// RQ13 - second output carries reactive, or apparent when selected
// RQ14 - second output choice set by mode bits 7 and 8
// RQ15 - third output fundamental active, fourth harmonic active
// RQ16 - period at least 160 ms gives 80 ms high, shorter gives half
// RQ17 - period below 10 ms is stretched to 10 ms, 5 ms high
// RQ18 - accumulate only while sum power exceeds its startup threshold
// RQ19 - a phase with |P|+|Q| below its threshold is excluded
// RQ20 - no-load flags in bits 14 and 15, no pulses in no-load
// RQ21 - start in no-load after reset
// RQ22 - every reset clears all block registers and state
// RQ23 - pulse outputs idle low; a pulse never starts during another
// RQ24 - thresholds must be programmed; until then the block stays no-load
`timescale 1ns/10ps
module epa_energy_pulse_accumulator #(
  parameter int MIN_PERIOD_CYC = epa_pkg::MIN_PERIOD_MS * epa_pkg::CLK_KHZ,
  parameter int LONG_PERIOD_CYC = epa_pkg::LONG_PERIOD_MS * epa_pkg::CLK_KHZ,
  parameter int LONG_WIDTH_CYC = epa_pkg::LONG_WIDTH_MS * epa_pkg::CLK_KHZ
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [2:0][31:0] activePowerIn,
  input wire logic [2:0][31:0] reactivePowerIn,
  input wire logic [2:0][31:0] apparentPowerIn,
  input wire logic [2:0][31:0] fundPowerIn,
  input wire logic [2:0][31:0] harmPowerIn,
  input wire logic regWe,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  output logic active_total_pulse_out,
  output logic reactive_or_apparent_pulse_out,
  output logic fundamental_active_pulse_out,
  output logic harmonic_active_pulse_out,
  output logic dirChangeIrq
);
  logic swRst;
  logic coreRst;
  logic [6:0] tickCnt;
  logic tick;
  logic [15:0] metering_mode_reg;
  logic [15:0] startup_active_power_threshold;
  logic [15:0] startReactiveTh;
  logic [15:0] startApparentTh;
  logic [15:0] phaseNoloadTh [3];
  logic [31:0] hundredth_pulse_energy_constant;
  logic dirIrqEnable;
  logic [7:0] dirFlags;
  logic dirChange;
  logic active_noload_flag;
  logic reactive_noload_flag;
  logic apparentNoload;
  logic [2:0] phaseLive;
  logic signed [31:0] phPow [5][3];
  logic signed [31:0] sumPow [5];
  logic signed [31:0] chPower [20];
  logic [19:0] chFwd;
  logic [19:0] chRev;
  logic [15:0] chFwdE [20];
  logic [15:0] chRevE [20];
  logic [3:0] cfEvent;
  logic [3:0] cfNoload;
  logic [3:0] cfOut;
  logic [15:0] next_rdata;
  logic [7:0] energyIdx;
  logic wrDirStatus;

  function automatic logic [31:0] magOf(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  // software reset acts exactly like the reset input [RQ22]
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      swRst <= 1'b0;
    else
      swRst <= regWe && regAddr == epa_pkg::SOFT_RESET_OFF && regWdata == epa_pkg::SOFT_RESET_KEY;
  end
  assign coreRst = srst | swRst; // [RQ22]

  // 1 MHz accumulation tick [RQ1]
  always_ff @(posedge sys_clk)
  begin
    if (coreRst)
      tickCnt <= '0;
    else
      tickCnt <= (tickCnt == 7'(epa_pkg::TICK_DIV - 1)) ? '0 : tickCnt + 7'd1;
  end
  assign tick = (tickCnt == 7'(epa_pkg::TICK_DIV - 1));

  // configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (coreRst)
    begin
      metering_mode_reg <= epa_pkg::METERING_MODE_RST;
      startup_active_power_threshold <= epa_pkg::START_TH_RST; // [RQ24]
      startReactiveTh <= epa_pkg::START_TH_RST;
      startApparentTh <= epa_pkg::START_TH_RST;
      hundredth_pulse_energy_constant <= epa_pkg::PL_CONST_RST;
      dirIrqEnable <= 1'b0;
      for (int i = 0; i < epa_pkg::NUM_PHASE; i++)
        phaseNoloadTh[i] <= epa_pkg::PHASE_NOLOAD_RST;
    end
    else if (regWe)
    begin
      case (regAddr)
        epa_pkg::METERING_MODE_OFF: metering_mode_reg <= regWdata;
        epa_pkg::PSTART_OFF: startup_active_power_threshold <= regWdata;
        epa_pkg::QSTART_OFF: startReactiveTh <= regWdata;
        epa_pkg::SSTART_OFF: startApparentTh <= regWdata;
        epa_pkg::PL_CONST_HI_OFF: hundredth_pulse_energy_constant[31:16] <= regWdata;
        epa_pkg::PL_CONST_LO_OFF: hundredth_pulse_energy_constant[15:0] <= regWdata;
        epa_pkg::DIR_IRQ_ENABLE_OFF: dirIrqEnable <= regWdata[0];
        epa_pkg::PHASE_NOLOAD_OFF: phaseNoloadTh[0] <= regWdata;
        epa_pkg::PHASE_NOLOAD_OFF + 8'h01: phaseNoloadTh[1] <= regWdata;
        epa_pkg::PHASE_NOLOAD_OFF + 8'h02: phaseNoloadTh[2] <= regWdata;
        default: ;
      endcase
    end
  end

  // per-phase exclusion and power routing
  for (genvar p = 0; p < epa_pkg::NUM_PHASE; p++)
  begin : g_phase
    logic [32:0] magPQ;
    assign magPQ = {1'b0, magOf(activePowerIn[p])} + {1'b0, magOf(reactivePowerIn[p])};
    assign phaseLive[p] = magPQ[32:16] >= {1'b0, phaseNoloadTh[p]}; // [RQ19]
    assign phPow[epa_pkg::QTY_ACT][p] = phaseLive[p] ? activePowerIn[p] : '0; // [RQ19]
    assign phPow[epa_pkg::QTY_REACT][p] = phaseLive[p] ? reactivePowerIn[p] : '0;
    assign phPow[epa_pkg::QTY_APP][p] = phaseLive[p] ? apparentPowerIn[p] : '0;
    assign phPow[epa_pkg::QTY_FUND][p] = phaseLive[p] ? fundPowerIn[p] : '0;
    assign phPow[epa_pkg::QTY_HARM][p] = phaseLive[p] ? harmPowerIn[p] : '0;
  end

  // sums of the phases enabled by mode bits 0..2; result wraps at 32 bits, so scale powers with headroom
  for (genvar q = 0; q < epa_pkg::NUM_QTY; q++)
  begin : g_sum
    logic absSel;
    assign absSel = (q == epa_pkg::QTY_REACT) ? metering_mode_reg[epa_pkg::MM_REACT_ABS_BIT]
      : (q == epa_pkg::QTY_APP) ? 1'b0 : metering_mode_reg[epa_pkg::MM_ACT_ABS_BIT];
    always_comb
    begin
      sumPow[q] = '0;
      for (int p = 0; p < epa_pkg::NUM_PHASE; p++)
        if (metering_mode_reg[epa_pkg::MM_PHASE_EN_LSB + p])
          sumPow[q] = sumPow[q] + (absSel ? $signed(magOf(phPow[q][p])) : phPow[q][p]); // [RQ9]
    end
  end

  // startup thresholds; no-load is the reset state [RQ18] [RQ21]
  always_ff @(posedge sys_clk)
  begin
    if (coreRst)
    begin
      active_noload_flag <= 1'b1; // [RQ21]
      reactive_noload_flag <= 1'b1;
      apparentNoload <= 1'b1;
    end
    else if (tick)
    begin
      active_noload_flag <= !(magOf(sumPow[epa_pkg::QTY_ACT]) >
        {startup_active_power_threshold, 16'hffff}); // [RQ18]
      reactive_noload_flag <= !(magOf(sumPow[epa_pkg::QTY_REACT]) > {startReactiveTh, 16'hffff});
      apparentNoload <= !(magOf(sumPow[epa_pkg::QTY_APP]) > {startApparentTh, 16'hffff});
    end
  end

  // 20 channels: total and decomposed energy registers [RQ10] [RQ11]
  for (genvar c = 0; c < epa_pkg::NUM_CH; c++)
  begin : g_chan
    localparam int GRP = c / epa_pkg::NUM_QTY;
    localparam int QTY = c % epa_pkg::NUM_QTY;
    epa_chan_if cif ();
    if (GRP == epa_pkg::GRP_SUM)
    begin : g_src_sum
      assign chPower[c] = sumPow[QTY];
    end
    else
    begin : g_src_ph
      assign chPower[c] = phPow[QTY][GRP];
    end
    assign cif.power = chPower[c];
    assign cif.quantum = hundredth_pulse_energy_constant; // [RQ2]
    assign cif.tick = tick;
    assign cif.hundredthRes = metering_mode_reg[epa_pkg::MM_RES_BIT]; // [RQ5]
    assign cif.enable = (QTY == epa_pkg::QTY_REACT) ? !reactive_noload_flag
      : (QTY == epa_pkg::QTY_APP) ? !apparentNoload : !active_noload_flag; // [RQ18]
    assign chFwd[c] = cif.fwdPulse;
    assign chRev[c] = cif.revPulse;
    assign chFwdE[c] = cif.fwdEnergy;
    assign chRevE[c] = cif.revEnergy;
    epa_channel u_chan (
      .sys_clk(sys_clk),
      .rst(coreRst),
      .ch(cif)
    );
  end

  // pulse sources for the four outputs
  localparam int CH_SUM_ACT = epa_pkg::GRP_SUM * epa_pkg::NUM_QTY + epa_pkg::QTY_ACT;
  localparam int CH_SUM_REACT = epa_pkg::GRP_SUM * epa_pkg::NUM_QTY + epa_pkg::QTY_REACT;
  localparam int CH_SUM_APP = epa_pkg::GRP_SUM * epa_pkg::NUM_QTY + epa_pkg::QTY_APP;
  localparam int CH_SUM_FUND = epa_pkg::GRP_SUM * epa_pkg::NUM_QTY + epa_pkg::QTY_FUND;
  localparam int CH_SUM_HARM = epa_pkg::GRP_SUM * epa_pkg::NUM_QTY + epa_pkg::QTY_HARM;
  logic cf2App;
  // apparent only when its bit is set; otherwise reactive is the default
  assign cf2App = metering_mode_reg[epa_pkg::MM_CF2_APP_BIT] &&
    !metering_mode_reg[epa_pkg::MM_CF2_REACT_BIT]; // [RQ14]
  assign cfEvent[0] = chFwd[CH_SUM_ACT] | chRev[CH_SUM_ACT]; // [RQ12]
  assign cfEvent[1] = cf2App ? chFwd[CH_SUM_APP]
    : (chFwd[CH_SUM_REACT] | chRev[CH_SUM_REACT]); // [RQ13]
  assign cfEvent[2] = chFwd[CH_SUM_FUND] | chRev[CH_SUM_FUND]; // [RQ15]
  assign cfEvent[3] = chFwd[CH_SUM_HARM] | chRev[CH_SUM_HARM]; // [RQ15]
  assign cfNoload[0] = active_noload_flag;
  assign cfNoload[1] = cf2App ? apparentNoload : reactive_noload_flag;
  assign cfNoload[2] = active_noload_flag;
  assign cfNoload[3] = active_noload_flag;

  // width regulation; the period is the time since the previous pulse start
  for (genvar k = 0; k < epa_pkg::NUM_CF; k++)
  begin : g_shaper
    epa_pkg::epa_shaper_e state;
    logic [3:0] pending;
    logic [24:0] gap;
    logic [24:0] hiCnt;
    logic start;
    // a pulse may start only after 10 ms and after the previous one ended
    assign start = state == epa_pkg::SH_IDLE && pending != '0 &&
      gap >= 25'(MIN_PERIOD_CYC) && !cfNoload[k]; // [RQ17] [RQ23] [RQ20]
    always_ff @(posedge sys_clk)
    begin
      if (coreRst)
      begin
        state <= epa_pkg::SH_IDLE;
        pending <= '0;
        gap <= '0;
        hiCnt <= '0;
        cfOut[k] <= 1'b0; // [RQ23]
      end
      else
      begin
        if (gap < 25'(LONG_PERIOD_CYC))
          gap <= gap + 25'd1;
        // pulses queue while the output is busy, saturating at 15
        if (cfNoload[k])
          pending <= '0; // [RQ20]
        else if (cfEvent[k] && !start && pending != 4'hf)
          pending <= pending + 4'd1;
        else if (start && !cfEvent[k])
          pending <= pending - 4'd1;
        case (state)
          epa_pkg::SH_IDLE:
          begin
            if (start)
            begin
              state <= epa_pkg::SH_HIGH;
              cfOut[k] <= 1'b1;
              gap <= '0;
              hiCnt <= (gap >= 25'(LONG_PERIOD_CYC)) ? 25'(LONG_WIDTH_CYC)
                : {1'b0, gap[24:1]}; // [RQ16] [RQ17]
            end
          end
          epa_pkg::SH_HIGH:
          begin
            if (hiCnt <= 25'd1)
            begin
              state <= epa_pkg::SH_IDLE;
              cfOut[k] <= 1'b0; // [RQ23]
            end
            else
              hiCnt <= hiCnt - 25'd1;
          end
          default:
          begin
            state <= epa_pkg::SH_IDLE;
            cfOut[k] <= 1'b0;
          end
        endcase
      end
    end
  end
  assign active_total_pulse_out = cfOut[0];
  assign reactive_or_apparent_pulse_out = cfOut[1];
  assign fundamental_active_pulse_out = cfOut[2];
  assign harmonic_active_pulse_out = cfOut[3];

  // direction flags: 1 = reverse; sticky change flag, set beats clear
  assign wrDirStatus = regWe && regAddr == epa_pkg::SYS_STATUS_ONE_OFF &&
    regWdata[epa_pkg::SS_DIR_CHANGE_BIT];
  for (genvar g = 0; g < epa_pkg::NUM_GRP; g++)
  begin : g_dir
    localparam int CA = g * epa_pkg::NUM_QTY + epa_pkg::QTY_ACT;
    localparam int CR = g * epa_pkg::NUM_QTY + epa_pkg::QTY_REACT;
    always_ff @(posedge sys_clk)
    begin
      if (coreRst)
      begin
        dirFlags[epa_pkg::SS_ACT_DIR_LSB + g] <= 1'b0;
        dirFlags[epa_pkg::SS_REACT_DIR_LSB + g] <= 1'b0;
      end
      else
      begin
        if (chFwd[CA] || chRev[CA])
          dirFlags[epa_pkg::SS_ACT_DIR_LSB + g] <= chRev[CA]; // [RQ7]
        if (chFwd[CR] || chRev[CR])
          dirFlags[epa_pkg::SS_REACT_DIR_LSB + g] <= chRev[CR]; // [RQ7]
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (coreRst)
    begin
      dirChange <= 1'b0;
      dirChangeIrq <= 1'b0;
    end
    else
    begin
      if ((chFwd[CH_SUM_ACT] || chRev[CH_SUM_ACT]) &&
          chRev[CH_SUM_ACT] != dirFlags[epa_pkg::SS_ACT_DIR_LSB + epa_pkg::GRP_SUM])
        dirChange <= 1'b1; // [RQ8]
      else if (wrDirStatus)
        dirChange <= 1'b0;
      dirChangeIrq <= dirChange && dirIrqEnable; // [RQ8]
    end
  end

  // register read, one cycle after the address
  assign energyIdx = regAddr - epa_pkg::ENERGY_BASE_OFF;
  always_comb
  begin
    next_rdata = '0;
    case (regAddr)
      epa_pkg::SYS_STATUS_ONE_OFF: next_rdata = {dirChange, 7'h00, dirFlags};
      epa_pkg::ENERGY_STATUS_ZERO_OFF:
      begin
        next_rdata[epa_pkg::ES_ACT_NOLOAD_BIT] = active_noload_flag; // [RQ20]
        next_rdata[epa_pkg::ES_REACT_NOLOAD_BIT] = reactive_noload_flag; // [RQ20]
        next_rdata[epa_pkg::ES_APP_NOLOAD_BIT] = apparentNoload;
      end
      epa_pkg::DIR_IRQ_ENABLE_OFF: next_rdata = {15'h0000, dirIrqEnable};
      epa_pkg::METERING_MODE_OFF: next_rdata = metering_mode_reg;
      epa_pkg::PSTART_OFF: next_rdata = startup_active_power_threshold;
      epa_pkg::QSTART_OFF: next_rdata = startReactiveTh;
      epa_pkg::SSTART_OFF: next_rdata = startApparentTh;
      epa_pkg::PL_CONST_HI_OFF: next_rdata = hundredth_pulse_energy_constant[31:16];
      epa_pkg::PL_CONST_LO_OFF: next_rdata = hundredth_pulse_energy_constant[15:0];
      epa_pkg::PHASE_NOLOAD_OFF: next_rdata = phaseNoloadTh[0];
      epa_pkg::PHASE_NOLOAD_OFF + 8'h01: next_rdata = phaseNoloadTh[1];
      epa_pkg::PHASE_NOLOAD_OFF + 8'h02: next_rdata = phaseNoloadTh[2];
      default:
      begin
        if (regAddr >= epa_pkg::ENERGY_BASE_OFF && energyIdx < epa_pkg::ENERGY_COUNT)
          next_rdata = energyIdx[0] ? chRevE[energyIdx[5:1]] : chFwdE[energyIdx[5:1]];
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (coreRst)
      regRdata <= '0;
    else
      regRdata <= next_rdata;
  end
endmodule // epa_energy_pulse_accumulator

// [dv/epa_energy_pulse_accumulator_props.sv]
// port assertions of the energy pulse accumulator
`timescale 1ns/10ps
module epa_energy_pulse_accumulator_props #(
  parameter int MIN_PERIOD_CYC = 40,
  parameter int LONG_PERIOD_CYC = 640,
  parameter int LONG_WIDTH_CYC = 320
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic regWe,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic active_total_pulse_out,
  input wire logic reactive_or_apparent_pulse_out,
  input wire logic fundamental_active_pulse_out,
  input wire logic harmonic_active_pulse_out,
  input wire logic dirChangeIrq
);
  logic [3:0] cf;
  int hiCnt [4];
  int gapCnt;
  int startGap;
  assign cf = {harmonic_active_pulse_out, fundamental_active_pulse_out,
    reactive_or_apparent_pulse_out, active_total_pulse_out};
  // high time per output, cleared while low
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < 4; i++)
      hiCnt[i] <= (cf[i] && !srst) ? hiCnt[i] + 1 : 0;
  end
  // time since last start; reset counts as a start
  always_ff @(posedge sys_clk)
  begin
    gapCnt <= (srst || $rose(cf[0])) ? 0 : gapCnt + 1;
    startGap <= $rose(cf[0]) ? gapCnt : startGap;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  reset_quiet_a: assert property ($fell(srst) |->
    regRdata == 16'h0000 && cf == 4'h0 && !dirChangeIrq) else $error("not quiet after reset");
  thresh_readback_a: assert property ((regWe && regAddr == 8'h35) ##1
    (!regWe && regAddr == 8'h35) |=> regRdata == $past(regWdata, 2)) else $error("bad readback");
  unmapped_zero_a: assert property (regAddr == 8'h7f |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  soft_reset_a: assert property ((regWe && regAddr == 8'h70 && regWdata == 16'h5a5a)
    ##1 (regAddr == 8'h35) [*2] |=> regRdata == 16'hffff) else $error("soft reset missed");
  width_range_a: assert property ($fell(cf[0]) |-> hiCnt[0] >= MIN_PERIOD_CYC / 2
    && hiCnt[0] <= LONG_WIDTH_CYC) else $error("pulse width out of range");
  long_width_a: assert property ($fell(cf[0]) && startGap >= LONG_PERIOD_CYC |->
    hiCnt[0] == LONG_WIDTH_CYC) else $error("long period width wrong");
  min_gap_a: assert property ($rose(cf[0]) |-> gapCnt >= MIN_PERIOD_CYC - 1)
    else $error("pulse starts too close");
  other_width_a: assert property (hiCnt[1] <= LONG_WIDTH_CYC && hiCnt[2] <= LONG_WIDTH_CYC
    && hiCnt[3] <= LONG_WIDTH_CYC) else $error("pulse held too long");
  cover property ($fell(cf[0]) && startGap >= LONG_PERIOD_CYC);
  cover property ($rose(dirChangeIrq));
  cover property ($rose(cf[1]));
endmodule // epa_energy_pulse_accumulator_props
bind epa_energy_pulse_accumulator epa_energy_pulse_accumulator_props #(
  .MIN_PERIOD_CYC(MIN_PERIOD_CYC), .LONG_PERIOD_CYC(LONG_PERIOD_CYC),
  .LONG_WIDTH_CYC(LONG_WIDTH_CYC)) props (.sys_clk(sys_clk), .srst(srst), .regWe(regWe),
  .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
  .active_total_pulse_out(active_total_pulse_out),
  .reactive_or_apparent_pulse_out(reactive_or_apparent_pulse_out),
  .fundamental_active_pulse_out(fundamental_active_pulse_out),
  .harmonic_active_pulse_out(harmonic_active_pulse_out), .dirChangeIrq(dirChangeIrq));

// [dv/epa_pulse_counter.sv]
// external counter of the four energy pulse outputs
`timescale 1ns/10ps
module epa_pulse_counter (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] pulse,
  output logic [3:0][7:0] pulseCnt
);
  logic [3:0] prev;
  // counts rising edges only, so a held level counts once
  always_ff @(posedge sys_clk)
  begin
    prev <= srst ? 4'h0 : pulse;
    for (int i = 0; i < 4; i++)
      pulseCnt[i] <= srst ? 8'h00 : pulseCnt[i] + 8'((pulse[i] && !prev[i]) ? 1 : 0);
  end
endmodule // epa_pulse_counter

// [dv/tb_energy_pulse_accumulator.sv]
// self-checking bench of the energy pulse accumulator
`timescale 1ns/10ps
module tb_energy_pulse_accumulator;
  logic sys_clk = 0;
  logic srst = 1;
  logic [2:0][31:0] pw [5];
  logic regWe = 0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic [15:0] regRdata;
  logic [3:0] cf;
  logic irq;
  logic [3:0][7:0] pulseCnt;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  epa_energy_pulse_accumulator #(.MIN_PERIOD_CYC(40), .LONG_PERIOD_CYC(640),
    .LONG_WIDTH_CYC(320)) DUT (.sys_clk(sys_clk), .srst(srst), .activePowerIn(pw[0]),
    .reactivePowerIn(pw[1]), .apparentPowerIn(pw[2]), .fundPowerIn(pw[3]),
    .harmPowerIn(pw[4]), .regWe(regWe), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .active_total_pulse_out(cf[0]),
    .reactive_or_apparent_pulse_out(cf[1]), .fundamental_active_pulse_out(cf[2]),
    .harmonic_active_pulse_out(cf[3]), .dirChangeIrq(irq));
  epa_pulse_counter counter (.sys_clk(sys_clk), .srst(srst), .pulse(cf), .pulseCnt(pulseCnt));
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  // each pulse takes about a hundred ticks; ceiling leaves ample margin
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    regWe = 1;
    regAddr = a;
    regWdata = d;
    @(posedge sys_clk);
    #1;
    regWe = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
    regAddr = a;
    repeat (2) @(posedge sys_clk);
    #1;
    check(regRdata & m, exp);
  endtask
  task automatic setPw(input logic [31:0] act, input logic [31:0] oth);
    for (int i = 0; i < 5; i++)
      pw[i] = {64'h0, (i == 0) ? act : oth};
  endtask
  task automatic waitCnt(input int i, input logic [7:0] n);
    for (int k = 0; k < 15000 && pulseCnt[i] !== n; k++)
      @(posedge sys_clk);
    #1;
    check({8'h00, pulseCnt[i]}, {8'h00, n});
  endtask
  // quantum a little above the test power so a quantum lands on nearly every tick
  task automatic arm(input logic [15:0] mode);
    wr(8'h31, 16'h0002);
    wr(8'h32, 16'h1000);
    wr(8'h33, mode);
    wr(8'h35, 16'h0001);
    rd(8'h35, 16'h0001, 16'hffff);
    wr(8'h36, 16'h0001);
    wr(8'h37, 16'h0001);
  endtask
  task automatic t_reset;
    rd(8'h33, 16'h0087, 16'hffff);
    rd(8'h35, 16'hffff, 16'hffff);
    rd(8'h71, 16'hc000, 16'hc000);
    rd(8'h7f, 16'h0000, 16'hffff);
    $display("test reset done");
  endtask
  task automatic t_noload;
    setPw(32'h0002_0000, 32'h0002_0000);
    repeat (3000) @(posedge sys_clk);
    #1;
    check({cf, 4'h0, pulseCnt[0]}, 16'h0000);
    rd(8'h9e, 16'h0000, 16'hffff);
    $display("test noload done");
  endtask
  task automatic t_forward;
    arm(16'h0087);
    for (int i = 0; i < 4; i++)
      waitCnt(i, 8'h01);
    rd(8'h71, 16'h0000, 16'hc000);
    for (int i = 0; i < 5; i++)
      rd(8'h9e + 8'(2 * i), 16'h000a, 16'hffff);
    rd(8'h80, 16'h000a, 16'hffff);
    rd(8'h9f, 16'h0000, 16'hffff);
    rd(8'h02, 16'h0000, 16'h0080);
    $display("test forward done");
  endtask
  task automatic t_reverse;
    wr(8'h05, 16'h0001);
    setPw(32'hfffe_0000, 32'h0002_0000);
    waitCnt(0, 8'h02);
    rd(8'h9f, 16'h000a, 16'hffff);
    rd(8'h02, 16'h8080, 16'h8080);
    check({15'h0, irq}, 16'h0001);
    wr(8'h02, 16'h8000);
    rd(8'h02, 16'h0000, 16'h8000);
    check({15'h0, irq}, 16'h0000);
    $display("test reverse done");
  endtask
  // let any pulse finish first, a reset would cut it short
  task automatic t_software_reset_reg;
    setPw(32'h0, 32'h0);
    repeat (400) @(posedge sys_clk);
    wr(8'h70, 16'h5a5a);
    rd(8'h35, 16'hffff, 16'hffff);
    rd(8'h9f, 16'h0000, 16'hffff);
    rd(8'h71, 16'hc000, 16'hc000);
    $display("test soft reset done");
  endtask
  task automatic t_resolution;
    arm(16'h0287);
    setPw(32'h0002_0000, 32'h0002_0000);
    waitCnt(0, 8'h03);
    rd(8'h9e, 16'h0064, 16'hffff);
    $display("test resolution done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    setPw(32'h0, 32'h0);
    repeat (12) @(posedge sys_clk);
    #1;
    srst = 0;
    t_reset();
    t_noload();
    t_forward();
    t_reverse();
    t_software_reset_reg();
    t_resolution();
    report_and_stop();
  end
endmodule // tb_energy_pulse_accumulator
